// ==== rtl/scan_port_pkg.sv ====
// Constants and types shared by the boundary-scan test port.
package scan_port_pkg;

  // Register lengths.
  localparam int IR_WIDTH    = 8;
  localparam int CHAIN_WIDTH = 18;
  localparam int SEL_WIDTH   = 2;

  // Values loaded at reset, at instruction capture and at bypass capture.
  localparam logic [7:0] IR_RESET_VALUE   = 8'h7F;
  localparam logic [7:0] IR_CAPTURE_VALUE = 8'h81;
  localparam logic [1:0] SEL_RESET_VALUE  = 2'h2;
  localparam logic       BYPASS_CAPTURE   = 1'b0;

  // Instruction codes on bits 6 to 0; bit 7 is ignored.
  localparam logic [6:0] OP_EXTEST  = 7'h00;
  localparam logic [6:0] OP_SAMPLE  = 7'h02;
  localparam logic [6:0] OP_INTEST  = 7'h03;
  localparam logic [6:0] OP_HIGHZ   = 7'h06;
  localparam logic [6:0] OP_CLAMP   = 7'h07;
  localparam logic [6:0] OP_RUNT    = 7'h09;
  localparam logic [6:0] OP_SCANSEL = 7'h0A;

  // Test-clock cycles with mode-select high that force reset.
  localparam int TMS_RESET_CYCLES = 5;

  // Data register chosen by the current instruction.
  typedef enum logic [1:0] {
    DR_BYPASS = 2'h0,
    DR_CHAIN  = 2'h1,
    DR_SELECT = 2'h2
  } dr_sel_type;

  // Controller states, one-hot.
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UP_DR  = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UP_IR  = 16'h8000
  } tap_state_type;

endpackage : scan_port_pkg

// ==== rtl/scan_port.sv ====
// Boundary-scan test access port sampled on the system clock.
//
// Behaviour
// - State advances only on test-clock rise.
// - Sample on rise, drive output on fall.
// - Sixteen states, six stable, ten transient.
// - Eight-bit instruction, 18, 2, 1-bit data.
// - Reset state keeps test logic disabled.
// - Five high mode-select cycles reach reset.
// - Reset loads instruction with bypass ones.
// - Reset loads operation select with 10.
// - Operations run only while idle.
// - Scan selection states left next cycle.
// - Chain, bypass capture on exiting edge; select holds.
// - Output enables driving lsb in shift.
// - Shift each rise, including exiting edge.
// - Output released on fall in first exit state.
// - Second exit returns to shift; pause holds.
// - Data shadow updates on update fall.
// - Instruction capture loads 10000001.
// - Instruction shift enables lsb, same timing.
// - New instruction takes effect on fall.
// - Shadow stage everywhere except bypass.
// - Shift moves serial data; update copies.
// - Only one register in serial path.
// - Bypass captures zero when selected.
// - Top bit ignored; unknown means bypass.
`timescale 1ns/100ps

module scan_port #(
  parameter int CHAIN_W = scan_port_pkg::CHAIN_WIDTH
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo_out,
  output logic                    tdo_oe,
  input  wire logic [CHAIN_W-1:0] pin_capture,
  output logic      [CHAIN_W-1:0] chain_out,
  output logic                    test_mode,
  output logic                    highz_mode,
  output logic                    clamp_mode,
  output logic      [1:0]         operation_select,
  output logic                    run_op,
  output logic                    word_valid,
  input  wire logic               word_ready,
  output logic      [CHAIN_W-1:0] word_data,
  output logic                    word_lost
);

  // All state of the port in one record.
  typedef struct packed {
    logic [2:0]                  tck_s;   // Clock pin synchroniser and prior level.
    logic [1:0]                  tms_s;   // Mode-select synchroniser.
    logic [1:0]                  tdi_s;   // Data-in synchroniser.
    scan_port_pkg::tap_state_type st;     // Controller state.
    logic [7:0]                  ir_sh;   // Instruction shift stage.
    logic [7:0]                  ir;      // Current instruction.
    logic [CHAIN_W-1:0]          ch_sh;   // Boundary chain shift stage.
    logic [CHAIN_W-1:0]          ch;      // Boundary chain shadow.
    logic [1:0]                  sel_sh;  // Operation select shift stage.
    logic [1:0]                  sel;     // Operation select shadow.
    logic                        byp;     // Bypass bit, no shadow.
    logic                        tdo;     // Serial output level.
    logic                        oe;      // Serial output enable.
    logic                        tmode;   // Test mode decoded.
    logic                        hiz;     // Outputs forced high impedance.
    logic                        clamp;   // Outputs clamped.
    logic                        run;     // Selected operation running.
    logic [CHAIN_W-1:0]          hd;      // Buffer head word.
    logic [CHAIN_W-1:0]          tl;      // Buffer spare word.
    logic                        hv;      // Head holds a word.
    logic                        tv;      // Spare holds a word.
    logic                        lost;    // A word found both entries full.
  } core_type;

  core_type q;  // Registered state.
  core_type c;  // Next state.

  // Synchronised pin views and test-clock edges.
  logic tck_rise;
  logic tck_fall;
  logic tms_v;
  logic tdi_v;
  scan_port_pkg::dr_sel_type dsel;

  // Maps the current instruction to its data register.
  function automatic scan_port_pkg::dr_sel_type pick_dr(input logic [7:0] op);
    case (op[6:0])
      scan_port_pkg::OP_EXTEST,
      scan_port_pkg::OP_SAMPLE,
      scan_port_pkg::OP_INTEST:  pick_dr = scan_port_pkg::DR_CHAIN;
      scan_port_pkg::OP_SCANSEL: pick_dr = scan_port_pkg::DR_SELECT;
      default:                   pick_dr = scan_port_pkg::DR_BYPASS;
    endcase
  endfunction : pick_dr

  // Edges come from the second and prior flops only.
  assign tck_rise = q.tck_s[1] & ~q.tck_s[2];
  assign tck_fall = ~q.tck_s[1] & q.tck_s[2];
  assign tms_v    = q.tms_s[1];
  assign tdi_v    = q.tdi_s[1];
  assign dsel     = pick_dr(q.ir);

  // Next-state logic for the whole port.
  always_comb
  begin
    c       = q;
    c.tck_s = {q.tck_s[1], q.tck_s[0], tck};
    c.tms_s = {q.tms_s[0], tms};
    c.tdi_s = {q.tdi_s[0], tdi};

    // Buffer drain: the spare moves up when the head leaves.
    if (q.hv && word_ready)
    begin
      c.hv = q.tv;
      c.hd = q.tl;
      c.tv = 1'b0;
    end

    if (tck_rise)
    begin
      case (q.st)
        scan_port_pkg::ST_RESET:
          c.st = tms_v ? scan_port_pkg::ST_RESET : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_IDLE:
          c.st = tms_v ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_SEL_DR:
          c.st = tms_v ? scan_port_pkg::ST_SEL_IR : scan_port_pkg::ST_CAP_DR;
        scan_port_pkg::ST_CAP_DR:
          c.st = tms_v ? scan_port_pkg::ST_EX1_DR : scan_port_pkg::ST_SH_DR;
        scan_port_pkg::ST_SH_DR:
          c.st = tms_v ? scan_port_pkg::ST_EX1_DR : scan_port_pkg::ST_SH_DR;
        scan_port_pkg::ST_EX1_DR:
          c.st = tms_v ? scan_port_pkg::ST_UP_DR : scan_port_pkg::ST_PA_DR;
        scan_port_pkg::ST_PA_DR:
          c.st = tms_v ? scan_port_pkg::ST_EX2_DR : scan_port_pkg::ST_PA_DR;
        scan_port_pkg::ST_EX2_DR:
          c.st = tms_v ? scan_port_pkg::ST_UP_DR : scan_port_pkg::ST_SH_DR;
        scan_port_pkg::ST_UP_DR:
          c.st = tms_v ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
        scan_port_pkg::ST_SEL_IR:
          c.st = tms_v ? scan_port_pkg::ST_RESET : scan_port_pkg::ST_CAP_IR;
        scan_port_pkg::ST_CAP_IR:
          c.st = tms_v ? scan_port_pkg::ST_EX1_IR : scan_port_pkg::ST_SH_IR;
        scan_port_pkg::ST_SH_IR:
          c.st = tms_v ? scan_port_pkg::ST_EX1_IR : scan_port_pkg::ST_SH_IR;
        scan_port_pkg::ST_EX1_IR:
          c.st = tms_v ? scan_port_pkg::ST_UP_IR : scan_port_pkg::ST_PA_IR;
        scan_port_pkg::ST_PA_IR:
          c.st = tms_v ? scan_port_pkg::ST_EX2_IR : scan_port_pkg::ST_PA_IR;
        scan_port_pkg::ST_EX2_IR:
          c.st = tms_v ? scan_port_pkg::ST_UP_IR : scan_port_pkg::ST_SH_IR;
        scan_port_pkg::ST_UP_IR:
          c.st = tms_v ? scan_port_pkg::ST_SEL_DR : scan_port_pkg::ST_IDLE;
        default:
          c.st = scan_port_pkg::ST_RESET;
      endcase

      if (q.st == scan_port_pkg::ST_CAP_DR)
      begin
        case (dsel)
          scan_port_pkg::DR_CHAIN:  c.ch_sh = pin_capture;
          scan_port_pkg::DR_BYPASS: c.byp = scan_port_pkg::BYPASS_CAPTURE;
          default:                  c.sel_sh = q.sel_sh;
        endcase
      end

      if (q.st == scan_port_pkg::ST_SH_DR)
      begin
        case (dsel)
          scan_port_pkg::DR_CHAIN:  c.ch_sh = {tdi_v, q.ch_sh[CHAIN_W-1:1]};
          scan_port_pkg::DR_SELECT: c.sel_sh = {tdi_v, q.sel_sh[1]};
          default:                  c.byp = tdi_v;
        endcase
      end

      if (q.st == scan_port_pkg::ST_CAP_IR)
        c.ir_sh = scan_port_pkg::IR_CAPTURE_VALUE;

      if (q.st == scan_port_pkg::ST_SH_IR)
        c.ir_sh = {tdi_v, q.ir_sh[7:1]};
    end

    // Falling edge: outputs and shadow stages change here.
    if (tck_fall)
    begin
      c.oe = (q.st == scan_port_pkg::ST_SH_DR) || (q.st == scan_port_pkg::ST_SH_IR);
      if (q.st == scan_port_pkg::ST_SH_IR)
        c.tdo = q.ir_sh[0];
      else if (dsel == scan_port_pkg::DR_CHAIN)
        c.tdo = q.ch_sh[0];
      else if (dsel == scan_port_pkg::DR_SELECT)
        c.tdo = q.sel_sh[0];
      else
        c.tdo = q.byp;

      if (q.st == scan_port_pkg::ST_UP_DR)
      begin
        if (dsel == scan_port_pkg::DR_CHAIN)
        begin
          c.ch = q.ch_sh;
          // Hand the word on; two entries absorb a stalled receiver.
          if (!c.hv)
          begin
            c.hv = 1'b1;
            c.hd = q.ch_sh;
          end
          else if (!c.tv)
          begin
            c.tv = 1'b1;
            c.tl = q.ch_sh;
          end
          else
            c.lost = 1'b1;
        end
        else if (dsel == scan_port_pkg::DR_SELECT)
          c.sel = q.sel_sh;
      end

      if (q.st == scan_port_pkg::ST_UP_IR)
        c.ir = q.ir_sh;
    end

    if (q.st == scan_port_pkg::ST_RESET)
    begin
      c.ir  = scan_port_pkg::IR_RESET_VALUE;
      c.sel = scan_port_pkg::SEL_RESET_VALUE;
    end

    // Modes decoded from the instruction in force next cycle.
    c.tmode = (c.ir[6:0] == scan_port_pkg::OP_EXTEST) ||
              (c.ir[6:0] == scan_port_pkg::OP_INTEST) ||
              (c.ir[6:0] == scan_port_pkg::OP_HIGHZ)  ||
              (c.ir[6:0] == scan_port_pkg::OP_CLAMP)  ||
              (c.ir[6:0] == scan_port_pkg::OP_RUNT);
    c.hiz   = (c.ir[6:0] == scan_port_pkg::OP_HIGHZ);
    c.clamp = (c.ir[6:0] == scan_port_pkg::OP_CLAMP);
    c.run   = (c.ir[6:0] == scan_port_pkg::OP_RUNT) && (c.st == scan_port_pkg::ST_IDLE);

    // Synchronous reset puts every field at a constant.
    if (!reset_n)
    begin
      c     = '0;
      c.st  = scan_port_pkg::ST_RESET;
      c.ir  = scan_port_pkg::IR_RESET_VALUE;
      c.sel = scan_port_pkg::SEL_RESET_VALUE;
    end
  end

  // Registers the next state on every clock.
  always_ff @(posedge sys_clk)
  begin
    q <= c;
  end

  // Outputs straight from the state record.
  assign tdo_out          = q.tdo;
  assign tdo_oe           = q.oe;
  assign chain_out        = q.ch;
  assign test_mode        = q.tmode;
  assign highz_mode       = q.hiz;
  assign clamp_mode       = q.clamp;
  assign operation_select = q.sel;
  assign run_op           = q.run;
  assign word_valid       = q.hv;
  assign word_data        = q.hd;
  assign word_lost        = q.lost;

  // Counts test-clock rises seen with mode-select high, for checking.
  logic [2:0] tms_hi_cnt;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || (tck_rise && !tms_v))
      tms_hi_cnt <= 3'h0;
    else if (tck_rise && tms_hi_cnt != 3'h7)
      tms_hi_cnt <= tms_hi_cnt + 3'h1;
  end

  // A rise seen in a given state.
  sequence rise_in(scan_port_pkg::tap_state_type s);
    tck_rise && q.st == s;
  endsequence

  // A fall seen in a given state.
  sequence fall_in(scan_port_pkg::tap_state_type s);
    tck_fall && q.st == s;
  endsequence

  tms_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tms_hi_cnt >= 3'(scan_port_pkg::TMS_RESET_CYCLES) |-> q.st == scan_port_pkg::ST_RESET)
    else $error("five high mode-select cycles did not reach reset");

  state_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !tck_rise |=> $stable(q.st))
    else $error("state changed without a test-clock rise");

  select_leave_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rise_in(scan_port_pkg::ST_SEL_DR) |=> q.st != scan_port_pkg::ST_SEL_DR)
    else $error("data-scan selection state was held");

  ir_capture_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rise_in(scan_port_pkg::ST_CAP_IR) |=> q.ir_sh == scan_port_pkg::IR_CAPTURE_VALUE)
    else $error("instruction capture value wrong");

  ir_shift_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rise_in(scan_port_pkg::ST_SH_IR) |=> q.ir_sh == {$past(tdi_v), $past(q.ir_sh[7:1])})
    else $error("instruction shift stage did not shift");

  ir_update_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fall_in(scan_port_pkg::ST_UP_IR) |=> q.ir == $past(q.ir_sh))
    else $error("instruction update did not take effect");

  ir_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    q.st == scan_port_pkg::ST_RESET |=> q.ir == scan_port_pkg::IR_RESET_VALUE && !test_mode)
    else $error("instruction not reset to bypass");

  sel_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    q.st == scan_port_pkg::ST_RESET |=> operation_select == scan_port_pkg::SEL_RESET_VALUE)
    else $error("operation select not reset");

  // Output floats after fall outside shift
  tdo_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tck_fall && q.st != scan_port_pkg::ST_SH_DR && q.st != scan_port_pkg::ST_SH_IR
    |=> !tdo_oe)
    else $error("serial output driven outside shift");

  bypass_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rise_in(scan_port_pkg::ST_CAP_DR) ##0 dsel == scan_port_pkg::DR_BYPASS |=> !q.byp)
    else $error("bypass did not capture zero");

  tdo_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fall_in(scan_port_pkg::ST_SH_IR) |=> tdo_oe && tdo_out == $past(q.ir_sh[0]))
    else $error("serial output not driving instruction lsb");

  chain_update_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    fall_in(scan_port_pkg::ST_UP_DR) ##0 dsel == scan_port_pkg::DR_CHAIN
    |=> chain_out == $past(q.ch_sh))
    else $error("chain shadow not updated from shift stage");

endmodule : scan_port

// ==== tb/scan_master.sv ====
// Model of the external scan controller that drives the test access port.
`timescale 1ns/100ps

module scan_master (
  input  wire logic sys_clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  // Serial output as seen on the board; the released pin is pulled high.
  logic tdo_line;
  // Output enable seen at the last test-clock rise.
  logic last_oe;
  // System clocks per test-clock level, giving a 320 ns test-clock period.
  int   half = 4;

  assign tdo_line = tdo_oe ? tdo_out : 1'b1;

  // The test clock stands low between frames.
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_oe = 1'b0;
  end

  // One test-clock period; levels change while the clock is low.
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (half) @(posedge sys_clk);
    tck <= 1'b1;
    q = tdo_line;
    last_oe = tdo_oe;
    repeat (half) @(posedge sys_clk);
    tck <= 1'b0;
  endtask : step

  // Enters a shift, forces reset with mode-select high, then parks in idle.
  // reset then idle
  task automatic to_reset();
    logic q;
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : to_reset

  // Full scan from idle back to idle, with an optional pause after bit p.
  task automatic scan(input logic ir, input int len, input logic [31:0] din,
                      input int p, output logic [31:0] dout, output int oe_n);
    logic q;
    dout = '0;
    oe_n = 0;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < len; i++)
    begin
      step((i == len - 1) || (i == p - 1), din[i], q);
      dout[i] = q;
      oe_n += int'(last_oe);
      // Pause, resume through the second exit, and shift on.
      if (i == p - 1 && i != len - 1)
      begin
        repeat (3) step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
      end
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan

endmodule : scan_master

// ==== tb/scan_port_tb_top.sv ====
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/100ps

`define CHECK(got, exp) \
  begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end

module scan_port_tb_top;
  localparam int CW = scan_port_pkg::CHAIN_WIDTH;

  // Design ports.
  logic          sys_clk, reset_n, tck, tms, tdi, tdo_out, tdo_oe;
  logic          test_mode, highz_mode, clamp_mode, run_op;
  logic          word_valid, word_ready, word_lost;
  logic [1:0]    operation_select;
  logic [CW-1:0] pin_capture, chain_out, word_data;
  // Counters, scan results and words still expected from the buffer.
  int            errors = 0;
  int            checks_done = 0;
  int            oe_n;
  logic [31:0]   din, dout;
  logic [CW-1:0] sent[$];
  // Instructions tried in turn; the last one leaves test mode on.
  logic [6:0]    ops[10] = '{7'h02, 7'h03, 7'h06, 7'h07, 7'h09, 7'h0A, 7'h01,
                             7'h04, 7'h7F, 7'h00};

  scan_port i_scan_port (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pin_capture(pin_capture),
    .chain_out(chain_out), .test_mode(test_mode), .highz_mode(highz_mode),
    .clamp_mode(clamp_mode), .operation_select(operation_select), .run_op(run_op),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .word_lost(word_lost)
  );

  scan_master i_scan_master (
    .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe)
  );

  // System clock of 40 ns.
  always #20 sys_clk = ~sys_clk;

  // Data scan length for an instruction; bypass is shifted eight times.
  function automatic int dr_len(input logic [6:0] op);
    if (op == 7'h00 || op == 7'h02 || op == 7'h03)
      return CW;
    if (op == scan_port_pkg::OP_SCANSEL)
      return scan_port_pkg::SEL_WIDTH;
    return 8;
  endfunction : dr_len

  // Loads an instruction and checks the capture pattern and the decoded modes.
  task automatic ir_load(input logic [7:0] op);
    i_scan_master.scan(1'b1, 8, {24'h0, op}, 0, dout, oe_n);
    repeat (2) @(posedge sys_clk);
    `CHECK(dout[7:0], 8'h81)
    `CHECK(oe_n, 8)
    `CHECK(tdo_oe, 1'b0)
    `CHECK(test_mode, (op[6:0] inside {7'h00, 7'h03, 7'h06, 7'h07, 7'h09}))
    `CHECK(highz_mode, (op[6:0] == 7'h06))
    `CHECK(clamp_mode, (op[6:0] == 7'h07))
    `CHECK(run_op, (op[6:0] == 7'h09))
  endtask : ir_load

  // Runs one data scan with random data, 01 for the select register, and checks what came out and was kept.
  task automatic dr_scan(input logic [6:0] op, input int p);
    int          n;
    logic [31:0] m;
    n = dr_len(op);
    m = (32'h1 << n) - 32'h1;
    din = $urandom & m;
    if (n == 2)
      din = 32'h1;
    pin_capture <= CW'($urandom);
    i_scan_master.scan(1'b0, n, din, p, dout, oe_n);
    `CHECK(oe_n, n)
    if (n == CW)
    begin
      `CHECK(dout[CW-1:0], pin_capture)
      `CHECK(chain_out, din[CW-1:0])
      sent.push_back(din[CW-1:0]);
    end
    else if (n == 2)
      `CHECK(operation_select, din[1:0])
    else
      `CHECK(dout & m, (din << 1) & m)
  endtask : dr_scan

  // Takes the head word of the buffer and compares it with the oldest update.
  task automatic pop_word();
    int w;
    w = 0;
    // Let one edge pass so that the head reflects any earlier hand-over.
    @(posedge sys_clk);
    while (word_valid !== 1'b1 && w < 50)
    begin
      @(posedge sys_clk);
      w++;
    end
    `CHECK(word_data, sent.pop_front())
    word_ready <= 1'b1;
    @(posedge sys_clk);
    word_ready <= 1'b0;
  endtask : pop_word

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Main sequence.
  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    word_ready = 1'b0;
    pin_capture = '0;
    void'($urandom(64));
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHECK(operation_select, 2'h2)
    `CHECK(tdo_oe, 1'b0)
    `CHECK(test_mode, 1'b0)
    i_scan_master.to_reset();
    // Every instruction, random top bit, chain scans paused mid-way.
    foreach (ops[k])
    begin
      ir_load({1'($urandom), ops[k]});
      dr_scan(ops[k], (dr_len(ops[k]) == CW) ? $urandom_range(CW - 1, 1) : 0);
      if (dr_len(ops[k]) == CW)
        pop_word();
    end
    // Forced reset from inside a data shift.
    // The chain was still selected: one exit-edge shift of a one, then an update.
    i_scan_master.to_reset();
    `CHECK(operation_select, 2'h2)
    `CHECK(test_mode, 1'b0)
    `CHECK(chain_out, {1'b1, pin_capture[CW-1:1]})
    sent.push_back({1'b1, pin_capture[CW-1:1]});
    pop_word();
    dr_scan(7'h7F, 0);
    // Stalled receiver: two words kept, the third dropped.
    ir_load(8'h02);
    repeat (3) dr_scan(7'h02, 0);
    `CHECK(word_lost, 1'b1)
    void'(sent.pop_back());
    repeat (2) pop_word();
    repeat (3) @(posedge sys_clk);
    `CHECK(word_valid, 1'b0)
    report_and_stop();
  end

  // Watchdog: the sequence needs well under 1 ms, so 3 ms means a hang.
  initial
  begin
    #3000000;
    errors++;
    report_and_stop();
  end

endmodule : scan_port_tb_top
